// file: nvb_pkg.sv
// package for the byte-wide nonvolatile store controller
// assumes a 200 MHz aclk and an AXI4-Lite register port
package nvb_pkg;
	localparam int          NVB_DEPTH        = 64;
	localparam int          NVB_AW           = 6;
	localparam logic [7:0]  NVB_ERASED       = 8'hFF;
	localparam logic [11:0] NVB_OFF_ADDR     = 12'h000;
	localparam logic [11:0] NVB_OFF_DATA     = 12'h004;
	localparam logic [11:0] NVB_OFF_CTRL     = 12'h008;
	localparam logic [11:0] NVB_OFF_OSC      = 12'h00C;
	localparam logic [11:0] NVB_OFF_STALL    = 12'h010;
	localparam int          NVB_CTRL_RD      = 0;
	localparam int          NVB_CTRL_PE      = 1;
	localparam int          NVB_CTRL_ME      = 2;
	localparam int          NVB_CTRL_MODE_LO = 4;
	localparam int          NVB_CTRL_MODE_HI = 5;
	localparam logic [1:0]  NVB_MODE_ATOMIC  = 2'h0;
	localparam logic [1:0]  NVB_MODE_ERASE   = 2'h1;
	localparam logic [1:0]  NVB_MODE_WRITE   = 2'h2;
	localparam logic [1:0]  NVB_MODE_RSVD    = 2'h3;
	localparam logic [7:0]  NVB_DATA_RST     = 8'h00;
	localparam logic [1:0]  NVB_MODE_RST     = 2'h0;
	localparam int          NVB_ARM_CYC      = 4;
	localparam int          NVB_RD_STALL     = 4;
	localparam int          NVB_WR_STALL     = 2;
	// times in microseconds; oscillator ticks at 1 MHz after calibration
	localparam int          NVB_T_ATOMIC_US  = 3400;
	localparam int          NVB_T_SPLIT_US   = 1800;
	localparam int          NVB_OSC_HZ       = 1000000;
	localparam int          NVB_T_ATOMIC_TK  = NVB_T_ATOMIC_US * (NVB_OSC_HZ / 1000000);
	localparam int          NVB_T_SPLIT_TK   = NVB_T_SPLIT_US * (NVB_OSC_HZ / 1000000);
	localparam int          NVB_CLK_HZ       = 200000000;
	localparam logic [7:0]  NVB_OSC_DIV_RST  = 8'(NVB_CLK_HZ / NVB_OSC_HZ - 1);
	localparam logic [1:0]  NVB_RESP_OK      = 2'h0;
	localparam logic [1:0]  NVB_RESP_SLVERR  = 2'h2;
	localparam logic [1:0]  NVB_RESP_DECERR  = 2'h3;
	typedef enum logic [1:0] {NVB_IDLE, NVB_ERASE_PH, NVB_WRITE_PH} nvb_state_e;
endpackage

// file: nvb_mem.sv
// byte array holding the nonvolatile contents
// one write port, registered read port, same clock
`timescale 1ns/100ps
module nvb_mem #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	// clock
	input  wire logic          aclk,
	// write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	// read port
	input  wire logic [AW-1:0] raddr,
	output logic      [7:0]    rdata_q
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end
endmodule // nvb_mem

// file: nvb_ctrl.sv
// register front end and programming sequencer for a 64-byte store
// assumes AXI4-Lite master, cpu_stall consumed by the core pipeline
`timescale 1ns/100ps
module nvb_ctrl
	import nvb_pkg::*;
#(
	parameter int T_ATOMIC = nvb_pkg::NVB_T_ATOMIC_TK,
	parameter int T_SPLIT  = nvb_pkg::NVB_T_SPLIT_TK
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// read address
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// processor hold and status
	output logic             cpu_stall,
	output logic             nv_busy
);
	import nvb_pkg::*;

	logic [NVB_AW-1:0] nv_byte_address_reg_q;
	logic [7:0]        nv_byte_data_reg_q;
	logic [1:0]        program_mode_field_q;
	logic              prog_en_q;
	logic              arm_q;
	logic [2:0]        arm_cnt_q;
	logic [7:0]        osc_div_q;
	logic [7:0]        osc_cnt_q;
	logic [12:0]       tick_left_q;
	nvb_state_e        state_q;
	logic [2:0]        stall_cnt_q;
	logic [1:0]        rd_pend_q;
	logic [11:0]       awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              aw_have_q;
	logic              w_have_q;
	logic [1:0]        bresp_q;
	logic              bvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;
	logic              rvalid_q;

	// write path: take address and data in either order
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready  = !w_have_q && !bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rvalid  = rvalid_q;

	wire        wr_go    = aw_have_q && w_have_q && !bvalid_q;
	wire [11:0] wr_off   = {awaddr_q[11:2], 2'b00};
	wire        wr_lane0 = wstrb_q[0];
	wire        wr_addr  = wr_go && wr_off == NVB_OFF_ADDR;
	wire        wr_data  = wr_go && wr_off == NVB_OFF_DATA;
	wire        wr_ctrl  = wr_go && wr_off == NVB_OFF_CTRL;
	wire        wr_osc   = wr_go && wr_off == NVB_OFF_OSC;
	wire        wr_hit   = wr_addr || wr_data || wr_ctrl || wr_osc;
	wire        busy     = state_q != NVB_IDLE;
	wire        rd_hit_w = s_axi_arvalid && s_axi_arready;
	wire [11:0] rd_off   = {s_axi_araddr[11:2], 2'b00};

	// program bit counts only while armed
	wire pe_req  = wr_ctrl && wr_lane0 && wdata_q[NVB_CTRL_PE] && arm_q;
	// a trigger during programming does nothing
	wire prog_go = pe_req && !busy && program_mode_field_q != NVB_MODE_RSVD;
	// reads refused as well while busy
	wire rd_req  = wr_ctrl && wr_lane0 && wdata_q[NVB_CTRL_RD] && !busy;
	wire me_set  = wr_ctrl && wr_lane0 && wdata_q[NVB_CTRL_ME];

	// oscillator tick derived from a calibrated divider
	wire osc_tick = osc_cnt_q == osc_div_q;

	wire [12:0] t_atomic = 13'(T_ATOMIC);
	wire [12:0] t_split  = 13'(T_SPLIT);

	// address bits beyond 63 are not stored
	wire [NVB_AW-1:0] wr_byte_addr = wdata_q[NVB_AW-1:0];

	logic [7:0] mem_rdata;
	logic       mem_we;
	logic [7:0] mem_wdata;

	nvb_mem #(
		.DEPTH (NVB_DEPTH),
		.AW    (NVB_AW)
	) u_mem (
		.aclk  (aclk),
		.we    (mem_we),
		.waddr (nv_byte_address_reg_q),
		.wdata (mem_wdata),
		.raddr (nv_byte_address_reg_q),
		.rdata_q (mem_rdata)
	);

	// write-only stores old AND new, as cells can only clear bits
	wire last_tick = osc_tick && tick_left_q == 13'h0001;
	assign mem_we    = (state_q == NVB_ERASE_PH || state_q == NVB_WRITE_PH) && last_tick;
	assign mem_wdata = state_q == NVB_ERASE_PH ? NVB_ERASED
		: (mem_rdata & nv_byte_data_reg_q);

	// address register has no reset value
	always_ff @(posedge aclk) begin
		if (wr_addr && wr_lane0 && !busy) begin
			nv_byte_address_reg_q <= wr_byte_addr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nv_byte_data_reg_q <= NVB_DATA_RST;
		end else if (rd_pend_q == 2'h1) begin
			nv_byte_data_reg_q <= mem_rdata;
		end else if (wr_data && wr_lane0) begin
			nv_byte_data_reg_q <= wdata_q[7:0];
		end
	end

	// mode frozen while program bit set
	always_ff @(posedge aclk) begin
		if (!aresetn && !busy) begin
			program_mode_field_q <= NVB_MODE_RST;
		// trigger write must not retarget the operation it starts
		end else if (aresetn && wr_ctrl && wr_lane0 && !prog_en_q && !prog_go) begin
			program_mode_field_q <= wdata_q[NVB_CTRL_MODE_HI:NVB_CTRL_MODE_LO];
		end
	end

	// arm window closes four cycles after set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arm_q     <= 1'b0;
			arm_cnt_q <= 3'h0;
		end else if (me_set) begin
			arm_q     <= 1'b1;
			arm_cnt_q <= 3'(NVB_ARM_CYC);
		end else if (arm_q) begin
			arm_cnt_q <= arm_cnt_q - 3'h1;
			arm_q     <= arm_cnt_q != 3'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_div_q <= NVB_OSC_DIV_RST;
		end else if (wr_osc && wr_lane0) begin
			osc_div_q <= wdata_q[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || osc_tick || !busy) begin
			osc_cnt_q <= 8'h00;
		end else begin
			osc_cnt_q <= osc_cnt_q + 8'h01;
		end
	end

	// mode 00 runs erase then write
	// phase lengths from the two durations
	// programming runs to completion even across a reset
	always_ff @(posedge aclk) begin
		if (prog_go) begin
			case (program_mode_field_q)
				NVB_MODE_ATOMIC: begin
					state_q     <= NVB_ERASE_PH;
					tick_left_q <= t_atomic - t_split;
				end
				NVB_MODE_ERASE: begin
					state_q     <= NVB_ERASE_PH;
					tick_left_q <= t_split;
				end
				default: begin
					state_q     <= NVB_WRITE_PH;
					tick_left_q <= t_split;
				end
			endcase
		end else if (busy && osc_tick) begin
			tick_left_q <= tick_left_q - 13'h0001;
			if (tick_left_q == 13'h0001) begin
				if (state_q == NVB_ERASE_PH && program_mode_field_q == NVB_MODE_ATOMIC) begin
					state_q     <= NVB_WRITE_PH;
					tick_left_q <= t_split;
				end else begin
					state_q <= NVB_IDLE;
				end
			end
		end else if (!aresetn) begin
			// case, not !busy: an unknown power-up state must still reset
			case (state_q)
				NVB_ERASE_PH, NVB_WRITE_PH: begin
					tick_left_q <= tick_left_q;
				end
				default: begin
					state_q     <= NVB_IDLE;
					tick_left_q <= 13'h0000;
				end
			endcase
		end
	end

	// program bit tracks the whole operation
	// software polls it to know when done
	always_ff @(posedge aclk) begin
		prog_en_q <= prog_go || (busy && !(osc_tick && tick_left_q == 13'h0001
			&& !(state_q == NVB_ERASE_PH && program_mode_field_q == NVB_MODE_ATOMIC)));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stall_cnt_q <= 3'h0;
		end else if (rd_req) begin
			stall_cnt_q <= 3'(NVB_RD_STALL);
		end else if (prog_go) begin
			stall_cnt_q <= 3'(NVB_WR_STALL);
		end else if (stall_cnt_q != 3'h0) begin
			stall_cnt_q <= stall_cnt_q - 3'h1;
		end
	end

	// read: memory output registered, data register loads a cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_pend_q <= 2'h0;
		end else if (rd_req) begin
			rd_pend_q <= 2'h2;
		end else if (rd_pend_q != 2'h0) begin
			rd_pend_q <= rd_pend_q - 2'h1;
		end
	end

	assign cpu_stall = stall_cnt_q != 3'h0;
	assign nv_busy   = prog_en_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= NVB_RESP_OK;
			awaddr_q  <= 12'h000;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? NVB_RESP_OK : NVB_RESP_DECERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= NVB_RESP_OK;
		end else if (rd_hit_w) begin
			rvalid_q <= 1'b1;
			rresp_q  <= NVB_RESP_OK;
			case (rd_off)
				NVB_OFF_ADDR:  rdata_q <= {26'h0, nv_byte_address_reg_q};
				NVB_OFF_DATA:  rdata_q <= {24'h0, nv_byte_data_reg_q};
				NVB_OFF_CTRL:  rdata_q <= {26'h0, program_mode_field_q, 1'b0,
					arm_q, prog_en_q, 1'b0};
				NVB_OFF_OSC:   rdata_q <= {24'h0, osc_div_q};
				NVB_OFF_STALL: rdata_q <= {29'h0, stall_cnt_q};
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= NVB_RESP_DECERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule // nvb_ctrl

// file: nvb_ctrl_props.sv
// checker for the store controller's bus and status ports
// assumes the bench keeps the oscillator divider below 200
`timescale 1ns/100ps
module nvb_ctrl_props (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// status
	input wire logic        cpu_stall,
	input wire logic        nv_busy
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// not cleared by reset: busy runs through it
	logic [10:0] busy_n_q;
	always_ff @(posedge aclk) begin
		if (!nv_busy) begin
			busy_n_q <= 11'h000;
		end else begin
			busy_n_q <= busy_n_q + 11'h001;
		end
	end
	chk_bvalid_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	chk_rdata_stable: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	chk_aw_refused: assert property (
		s_axi_bvalid |-> !s_axi_awready) else $error("aw taken during response");
	chk_ar_refused: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("ar taken during response");
	chk_rdata_upper: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
	chk_stall_span: assert property (
		$rose(cpu_stall) |-> cpu_stall[*2] ##[1:3] !cpu_stall) else $error("stall length");
	chk_busy_min: assert property (
		$rose(nv_busy) |-> nv_busy[*3]) else $error("busy too short");
	chk_busy_max: assert property (
		busy_n_q < 11'h514) else $error("busy too long");
endmodule // nvb_ctrl_props

bind nvb_ctrl nvb_ctrl_props u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.cpu_stall, .nv_busy);

// file: tb_top.sv
// self-checking bench for the store controller
// bench is the bus master; short tick counts keep the run brief
`timescale 1ns/100ps
module tb_top;
	import nvb_pkg::*;
	localparam int TA = 6;
	localparam int TS = 3;
	localparam int DV = 3;
	localparam logic [1:0] OK = NVB_RESP_OK;
	logic        aclk, aresetn, cpu_stall, nv_busy;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_wstrb;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	int          num_errors, n_checks, seed, bl, bl_last, i;
	logic [5:0]  a;
	logic [7:0]  d;
	nvb_ctrl #(.T_ATOMIC(TA), .T_SPLIT(TS)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .cpu_stall, .nv_busy);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		if (num_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic tmo(input int k);
		if (k >= 2000) begin
			num_errors++;
			end_of_test;
		end
	endtask
	// bready stays up between writes so no step assigns it twice
	task automatic wr(input logic [11:0] ad, input logic [31:0] dt, input logic [1:0] rs);
		int k;
		bq.push_back(rs);
		s_axi_awaddr <= ad;
		s_axi_wdata <= dt;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		s_axi_rready <= 1'b0;
		for (k = 0; k < 2000; k++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		tmo(k);
	endtask
	task automatic rd(input logic [11:0] ad, input logic [33:0] ex);
		int k;
		rq.push_back(ex);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		s_axi_bready <= 1'b0;
		for (k = 0; k < 2000; k++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		tmo(k);
	endtask
	// core is held: no bus access until the stall ends
	task automatic hold(input int e);
		int k;
		for (k = 0; k < 2000 && cpu_stall !== 1'b0; k++) @(posedge aclk);
		tmo(k);
		check(34'(k), 34'(e));
	endtask
	task automatic prog(input logic [1:0] m, input logic [5:0] ad, input logic [7:0] dt);
		wr(NVB_OFF_ADDR, 32'(ad), OK);
		wr(NVB_OFF_DATA, 32'(dt), OK);
		wr(NVB_OFF_CTRL, {26'h0, m, 4'h4}, OK);
		wr(NVB_OFF_CTRL, {26'h0, m, 4'h2}, OK);
		hold(NVB_WR_STALL);
	endtask
	task automatic peek(input logic [5:0] ad, input logic [7:0] ex);
		wr(NVB_OFF_ADDR, 32'(ad), OK);
		wr(NVB_OFF_CTRL, 32'h1, OK);
		hold(NVB_RD_STALL);
		rd(NVB_OFF_DATA, {26'h0, ex});
	endtask
	task automatic idle(input int e);
		int k;
		@(posedge aclk);
		for (k = 0; k < 2000 && nv_busy !== 1'b0; k++) @(posedge aclk);
		tmo(k);
		@(posedge aclk);
		if (e > 0) check(34'(bl_last >= e - 4 && bl_last <= e + 5), 34'h1);
	endtask
	always @(posedge aclk) begin
		if (nv_busy === 1'b1) begin
			bl <= bl + 1;
		end else if (bl != 0) begin
			bl_last <= bl;
			bl <= 0;
		end
	end
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
			check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
			check({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
	end
	initial begin
		repeat (50000) @(posedge aclk);
		num_errors++;
		end_of_test;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{num_errors, n_checks, bl, bl_last} = '0;
		seed = 29;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(NVB_OFF_DATA, {26'h0, NVB_DATA_RST});
		rd(NVB_OFF_CTRL, 34'h0);
		rd(12'h100, {NVB_RESP_DECERR, 32'h0});
		rd(NVB_OFF_STALL, 34'h0);
		wr(12'h100, 32'h0, NVB_RESP_DECERR);
		wr(NVB_OFF_OSC, 32'(DV), OK);
		for (i = 0; i < 4; i++) begin
			a = i < 2 ? 6'(-i) : 6'($random(seed));
			d = 8'($random(seed));
			prog(NVB_MODE_ATOMIC, a, d);
			idle(TA * (DV + 1));
			peek(a, d);
		end
		prog(NVB_MODE_ERASE, a, d);
		idle(TS * (DV + 1));
		peek(a, NVB_ERASED);
		d = 8'($random(seed));
		prog(NVB_MODE_WRITE, a, d);
		idle(TS * (DV + 1));
		peek(a, d);
		wr(NVB_OFF_DATA, 32'h0, OK);
		s_axi_wstrb <= 4'hE;
		wr(NVB_OFF_DATA, 32'h5A, OK);
		s_axi_wstrb <= 4'hF;
		rd(NVB_OFF_DATA, 34'h0);
		wr(NVB_OFF_CTRL, 32'h2, OK);
		hold(0);
		wr(NVB_OFF_CTRL, 32'h4, OK);
		repeat (6) @(posedge aclk);
		wr(NVB_OFF_CTRL, 32'h2, OK);
		hold(0);
		wr(NVB_OFF_CTRL, 32'h34, OK);
		wr(NVB_OFF_CTRL, 32'h32, OK);
		hold(0);
		rd(NVB_OFF_CTRL, 34'h30);
		peek(a, d);
		prog(NVB_MODE_ATOMIC, a, ~d);
		wr(NVB_OFF_CTRL, 32'h20, OK);
		wr(NVB_OFF_ADDR, 32'(~a), OK);
		idle(TA * (DV + 1));
		rd(NVB_OFF_CTRL, 34'h0);
		rd(NVB_OFF_ADDR, {28'h0, a});
		peek(a, ~d);
		wr(NVB_OFF_OSC, 32'h14, OK);
		prog(NVB_MODE_ERASE, a, d);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(NVB_OFF_CTRL, 34'h12);
		idle(0);
		rd(NVB_OFF_CTRL, 34'h10);
		peek(a, NVB_ERASED);
		end_of_test;
	end
endmodule // tb_top
